// File: hdl/avp_core.v
// Contract
// - Mean mode ignores unipolar, suppression, smoothing
// - Mean mode accumulates one sample per read
// - Transfer trigger outputs mean, clears accumulator
// - Partner request also outputs mean, restarts
// - Out-of-range sample makes mean invalid code
// - New period starts after invalid mean
// - Mean mode forces suppression time zero
// - Unipolar clips negative values to zero
// - Hardware source passes wire break code
// - Software source clips all negatives, except the underflow code on the threshold path
// - Suppress fault code for suppression time
// - In-range return sends value, drops fault
// - Suppression, smoothing, limits need threshold trigger
// - Smoothing y=(x+(k-1)y)/k each cycle
// - Smoothing factor only 1,4,32,64
// - Hardware source uses fixed raw limits
// - Limits are signed 16-bit raw values
// - Raw ranges 27648,32511,32767,-32512,-32768
// - Zero limit means limit disabled
// - Stored nonzero limit evaluated only for software source
// - No threshold trigger passes value unsmoothed, with only the unipolar clip applied
`timescale 1ns/1ps
`default_nettype none
`include "avp_map.vh"
module avp_core #(
  parameter READ_CYC = `AVP_READ_CYC,
  parameter CALC_CYC = `AVP_CALC_CYC
) (
  input wire mclk,
  input wire rst,
  input wire [15:0] sample_in,
  input wire xfer_trig,
  input wire partner_req,
  output reg [15:0] value_out,
  output reg value_vld,
  output reg lim_lo_hit,
  output reg lim_hi_hit,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o
);
  // Software-visible configuration
  reg [5:0] ctrl_r;
  reg [15:0] lim_lo_r;
  reg [15:0] lim_hi_r;
  reg [15:0] fst_r;

  // Synchroniser stages and edge-detect history
  reg [15:0] s1_r;
  reg [15:0] s2_r;
  reg trig_s1_r;
  reg trig_s2_r;
  reg req_s1_r;
  reg req_s2_r;
  reg trig_d_r;
  reg req_d_r;

  // Read and calculation cycle timers
  reg [22:0] rd_cnt_r;
  reg [22:0] calc_cnt_r;

  // Fault suppression count, in calculation cycles
  reg [15:0] fst_cnt_r;
  reg fault_pend_r;

  // Mean accumulator, sample count and the stored invalid code
  reg [31:0] acc_r;
  reg [15:0] nsamp_r;
  reg [15:0] inv_r;
  reg inv_flag_r;

  // Smoothing state and the value the limits are checked against
  reg [15:0] smooth_r;
  reg [15:0] proc_r;

  // Overflow and underflow codes bypass averaging and smoothing
  function raw_fault;
    input [15:0] v;
    begin
      raw_fault = (v == `AVP_OVF) || (v == `AVP_UNF);
    end
  endfunction

  // Mode decode
  wire mean_en = ctrl_r[`AVP_C_MEAN];
  wire thr_en = ctrl_r[`AVP_C_THR];
  wire hw_src = ctrl_r[`AVP_C_HWSRC];

  // Timer ticks
  wire read_tick = (rd_cnt_r == 23'd0);
  wire calc_tick = (calc_cnt_r == 23'd0);

  // Rising edges of the synchronised request levels
  wire trig_ev = trig_s2_r & ~trig_d_r;
  wire req_ev = req_s2_r & ~req_d_r;
  wire xfer_ev = trig_ev | req_ev;
  wire is_fault = raw_fault(s2_r);

  // Shift for smoothing factor; only four settings exist
  function [2:0] sm_shift;
    input [1:0] code;
    begin
      case (code)
        `AVP_SM_K4: sm_shift = 3'd2;
        `AVP_SM_K32: sm_shift = 3'd5;
        `AVP_SM_K64: sm_shift = 3'd6;
        default: sm_shift = 3'd0;
      endcase
    end
  endfunction

  // Raw value synchroniser; the word is assumed to change slowly against mclk
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_r <= 16'h0000;
      s2_r <= 16'h0000;
    end else begin
      s1_r <= sample_in;
      s2_r <= s1_r;
    end
  end

  // Request synchronisers; history flops start low, so no false edge after reset
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      trig_d_r <= 1'b0;
      req_d_r <= 1'b0;
    end else begin
      trig_s1_r <= xfer_trig;
      trig_s2_r <= trig_s1_r;
      req_s1_r <= partner_req;
      req_s2_r <= req_s1_r;
      trig_d_r <= trig_s2_r;
      req_d_r <= req_s2_r;
    end
  end

  // Read cycle timer; one tick every READ_CYC clocks
  always @(posedge mclk or posedge rst) begin
    if (rst)
      rd_cnt_r <= 23'd0;
    else
      rd_cnt_r <= read_tick ? READ_CYC[22:0] - 23'd1 : rd_cnt_r - 23'd1;
  end

  // Calculation cycle timer, free running so ticks stay evenly spaced
  always @(posedge mclk or posedge rst) begin
    if (rst)
      calc_cnt_r <= 23'd0;
    else
      calc_cnt_r <= calc_tick ? CALC_CYC[22:0] - 23'd1 : calc_cnt_r - 23'd1;
  end

  // Unipolar clip, skipped in mean mode
  reg [15:0] uni_v;
  always @* begin
    uni_v = s2_r;
    if (ctrl_r[`AVP_C_UNI] && !mean_en && s2_r[15]) begin
      // Wire break code survives only for hardware sources
      // Software sources have no such code, so every negative value clips
      if (hw_src && s2_r == `AVP_UNF)
        uni_v = s2_r;
      else
        uni_v = 16'h0000;
    end
  end

  // Smoothing, one step per calculation tick; k=1 passes through
  wire [2:0] sh = mean_en ? 3'd0 : sm_shift(ctrl_r[`AVP_C_SM_HI:`AVP_C_SM_LO]);
  wire signed [23:0] sm_x = {{8{uni_v[15]}}, uni_v};
  wire signed [23:0] sm_y = {{8{smooth_r[15]}}, smooth_r};
  // x + (k-1)y formed as x + (y << s) - y; 24 bits cover the growth for k=64
  // The arithmetic shift divides; it rounds toward minus infinity
  wire signed [23:0] sm_sum = sm_x + (sm_y <<< sh) - sm_y;
  wire signed [23:0] sm_q = sm_sum >>> sh;
  wire [15:0] sm_new = (sh == 3'd0) ? uni_v : sm_q[15:0];

  // Limit check; fixed raw limits for hardware operands
  // Compare is strict; a limit of zero switches that side off
  wire [15:0] eff_lo = hw_src ? `AVP_UNR_MIN : lim_lo_r;
  wire [15:0] eff_hi = hw_src ? `AVP_OVR_MAX : lim_hi_r;
  wire lo_hit = (eff_lo != 16'h0000) && ($signed(proc_r) < $signed(eff_lo));
  wire hi_hit = (eff_hi != 16'h0000) && ($signed(proc_r) > $signed(eff_hi));

  // Effective suppression time is zero in mean mode
  wire [15:0] fst_eff = mean_en ? 16'h0000 : fst_r;

  // Mean division is done once per transfer; combinational divider kept simple
  // An empty period gives zero rather than a divide by zero
  wire [31:0] mean_q = (nsamp_r == 16'h0000) ? 32'h0 :
    $unsigned($signed(acc_r) / $signed({16'h0000, nsamp_r}));

  // Processing pipeline: mean mode, transparent path or threshold path
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Zero output and no pending fault out of reset
      acc_r <= 32'h0;
      nsamp_r <= 16'h0000;
      inv_r <= 16'h0000;
      inv_flag_r <= 1'b0;
      smooth_r <= 16'h0000;
      proc_r <= 16'h0000;
      fault_pend_r <= 1'b0;
      fst_cnt_r <= 16'h0000;
      value_out <= 16'h0000;
      value_vld <= 1'b0;
    end else begin
      value_vld <= 1'b0;
      if (mean_en) begin
        // Mean mode ignores unipolar, suppression and smoothing settings
        if (xfer_ev) begin
          // A transfer wins over a read tick in the same cycle; that sample is lost
          value_out <= inv_flag_r ? inv_r : mean_q[15:0];
          value_vld <= 1'b1;
          acc_r <= 32'h0;
          nsamp_r <= 16'h0000;
          inv_flag_r <= 1'b0;
        end else if (read_tick) begin
          if (is_fault) begin
            inv_flag_r <= 1'b1;
            inv_r <= s2_r;
          end else if (!inv_flag_r && nsamp_r != 16'hffff) begin
            // Count saturates after hours of averaging rather than wrapping
            acc_r <= acc_r + {{16{s2_r[15]}}, s2_r};
            nsamp_r <= nsamp_r + 16'h0001;
          end
        end
      end else if (!thr_en) begin
        // Transparent path, updated well inside the calculation cycle
        if (read_tick) begin
          proc_r <= uni_v;
          value_out <= uni_v;
          value_vld <= 1'b1;
        end
      end else if (calc_tick) begin
        // Threshold path: one smoothing step per calculation cycle
        smooth_r <= sm_new;
        proc_r <= sm_new;
        if (is_fault && fst_eff != 16'h0000) begin
          // Hold the fault code back while the count runs
          if (!fault_pend_r) begin
            fault_pend_r <= 1'b1;
            fst_cnt_r <= fst_eff;
          end else if (fst_cnt_r <= 16'h0001) begin
            // Still pending when the time is up, so it goes out
            fst_cnt_r <= 16'h0000;
            value_out <= s2_r;
            value_vld <= 1'b1;
          end else begin
            fst_cnt_r <= fst_cnt_r - 16'h0001;
          end
        end else begin
          // Back in range or no suppression: drop any pending fault
          fault_pend_r <= 1'b0;
          fst_cnt_r <= 16'h0000;
          value_out <= is_fault ? s2_r : sm_new;
          value_vld <= 1'b1;
        end
      end
    end
  end

  // Limit flags only mean something on the threshold path; held low elsewhere
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      lim_lo_hit <= 1'b0;
      lim_hi_hit <= 1'b0;
    end else begin
      lim_lo_hit <= thr_en && !mean_en && lo_hit;
      lim_hi_hit <= thr_en && !mean_en && hi_hit;
    end
  end

  // Status word: invalid mean, fault pending, low and high limit flags
  wire [31:0] stat_w = {28'h0, lim_hi_hit, lim_lo_hit, fault_pend_r, inv_flag_r};

  // Read multiplexer; unmapped offsets read as zero
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0;
    case (wb_adr_i)
      `AVP_CTRL_OFS: rd_nxt = {26'h0, ctrl_r};
      `AVP_LIMLO_OFS: rd_nxt = {16'h0, lim_lo_r};
      `AVP_LIMHI_OFS: rd_nxt = {16'h0, lim_hi_r};
      `AVP_FST_OFS: rd_nxt = {16'h0, fst_eff};
      `AVP_OUT_OFS: rd_nxt = {16'h0, value_out};
      `AVP_STAT_OFS: rd_nxt = stat_w;
      `AVP_CNT_OFS: rd_nxt = {16'h0, nsamp_r};
      default: rd_nxt = 32'h0;
    endcase
  end

  // Wishbone slave, ack one cycle after strobe, dropped the next cycle
  // Gating on ack keeps a held strobe from being taken twice
  wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl_r <= `AVP_CTRL_RST;
      lim_lo_r <= 16'h0000;
      lim_hi_r <= 16'h0000;
      fst_r <= 16'h0000;
    end else begin
      wb_ack_o <= wb_hit;
      // Only the two low byte lanes carry register bits
      if (wb_hit && wb_we_i) begin
        case (wb_adr_i)
          `AVP_CTRL_OFS: if (wb_sel_i[0]) ctrl_r <= wb_dat_i[5:0];
          `AVP_LIMLO_OFS: begin
            if (wb_sel_i[0]) lim_lo_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) lim_lo_r[15:8] <= wb_dat_i[15:8];
          end
          `AVP_LIMHI_OFS: begin
            if (wb_sel_i[0]) lim_hi_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) lim_hi_r[15:8] <= wb_dat_i[15:8];
          end
          `AVP_FST_OFS: begin
            if (wb_sel_i[0]) fst_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) fst_r[15:8] <= wb_dat_i[15:8];
          end
          default: ;
        endcase
      end
      if (wb_hit && !wb_we_i)
        wb_dat_o <= rd_nxt;
    end
  end
endmodule // avp_core
`default_nettype wire

// File: hdl/avp_map.vh
`ifndef AVP_MAP_VH
`define AVP_MAP_VH
// Register offsets (byte addresses on the Wishbone slave)
`define AVP_CTRL_OFS 8'h00
`define AVP_LIMLO_OFS 8'h04
`define AVP_LIMHI_OFS 8'h08
`define AVP_FST_OFS 8'h0c
`define AVP_OUT_OFS 8'h10
`define AVP_STAT_OFS 8'h14
`define AVP_CNT_OFS 8'h18
// Control fields
`define AVP_C_MEAN 0
`define AVP_C_UNI 1
`define AVP_C_HWSRC 2
`define AVP_C_THR 3
`define AVP_C_SM_LO 4
`define AVP_C_SM_HI 5
`define AVP_CTRL_RST 6'h00
// Smoothing codes
`define AVP_SM_K1 2'h0
`define AVP_SM_K4 2'h1
`define AVP_SM_K32 2'h2
`define AVP_SM_K64 2'h3
// Raw value codes
`define AVP_OVF 16'h7fff
`define AVP_UNF 16'h8000
`define AVP_NOM_MAX 16'h6c00
`define AVP_OVR_MAX 16'h7eff
`define AVP_UNR_MIN 16'h8100
// Timing at 10 MHz
`define AVP_CLK_HZ 10000000
`define AVP_READ_MS 100
`define AVP_CALC_MS 500
`define AVP_READ_CYC ((`AVP_CLK_HZ / 1000) * `AVP_READ_MS)
`define AVP_CALC_CYC ((`AVP_CLK_HZ / 1000) * `AVP_CALC_MS)
`endif

// File: sim/avp_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module avp_properties (
  input wire mclk,
  input wire rst,
  input wire [15:0] value_out,
  input wire value_vld,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o
);
  logic [5:0] ctrl_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Shadow of the control byte, so output checks know the mode in force
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) ctrl_r <= 6'h00;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00) ctrl_r <= wb_dat_i[5:0];
  end
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  vld_pulse_a: assert property (value_vld |=> !value_vld) else $error("vld too long");
  quiet_release_a: assert property ($fell(rst) |-> !value_vld && !wb_ack_o) else $error("busy at reset");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h18 |-> wb_dat_o == 32'h0)
    else $error("unmapped read");
  fst_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h0c && ctrl_r[0] |-> wb_dat_o == 32'h0)
    else $error("suppression not zero");
  sw_clip_a: assert property (value_vld && ctrl_r[2:0] == 3'b010 |-> !value_out[15])
    else $error("negative passed");
  hw_clip_a: assert property (value_vld && ctrl_r[2:0] == 3'b110 |-> !value_out[15] || value_out == 16'h8000)
    else $error("bad clip");
endmodule // avp_properties
bind avp_core avp_properties u_avp_properties (.mclk, .rst, .value_out, .value_vld, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o);
`default_nettype wire

// File: sim/avp_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module avp_src_model (
  input wire logic mclk,
  output logic [15:0] sample_in,
  output logic xfer_trig,
  output logic partner_req
);
  initial {sample_in, xfer_trig, partner_req} = 18'h0;
  // Process value changes just after an edge
  task automatic put(input logic [15:0] v);
    @(posedge mclk);
    sample_in <= v;
  endtask
  // Level held long enough for the synchronised edge to be seen
  task automatic fire(input logic req);
    @(posedge mclk);
    {partner_req, xfer_trig} <= {req, !req};
    repeat (6) @(posedge mclk);
    {partner_req, xfer_trig} <= 2'b00;
  endtask
endmodule // avp_src_model
`default_nettype wire

// File: sim/tb_analog_value_preprocessor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_analog_value_preprocessor;
  logic mclk, rst, cyc, stb, we;
  logic [7:0] adr;
  logic [31:0] dat, rd;
  wire [15:0] smp, value_out;
  wire xfer, preq, value_vld, lo_hit, hi_hit, ack;
  wire [31:0] dat_o;
  int err_total, samples_checked;
  logic [37:0] pt [5] = '{{6'h02, 16'hfffb, 16'h0}, {6'h02, 16'h8000, 16'h0}, {6'h06, 16'h8000, 16'h8000},
    {6'h06, 16'hfff0, 16'h0}, {6'h00, 16'hfff0, 16'hfff0}};
  logic [32:0] mt [4] = '{{16'hfffc, 1'b0, 16'hfffc}, {16'h7fff, 1'b1, 16'h7fff}, {16'h8000, 1'b0, 16'h8000},
    {16'h0100, 1'b1, 16'h0100}};
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  avp_core #(.READ_CYC(10), .CALC_CYC(50)) u_avp_core (.mclk(mclk), .rst(rst), .sample_in(smp), .xfer_trig(xfer),
    .partner_req(preq), .value_out(value_out), .value_vld(value_vld), .lim_lo_hit(lo_hit), .lim_hi_hit(hi_hit),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h3),
    .wb_dat_o(dat_o), .wb_ack_o(ack));
  avp_src_model u_avp_src_model (.mclk(mclk), .sample_in(smp), .xfer_trig(xfer), .partner_req(preq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One classic cycle, released only after the edge that saw ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge mclk); while (ack !== 1'b1);
    rd = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic vld(input int n);
    repeat (n) begin
      @(negedge mclk);
      while (value_vld !== 1'b1) @(negedge mclk);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog sized well above the fewer than two thousand cycles the tests need
  initial begin
    #2000000;
    err_total++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    {cyc, stb, we, adr, dat} = 43'h0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 8'h1c, 32'h55);
    bus(1'b0, 8'h1c, 32'h0);
    check(rd, 32'h0);
    // Direct path; the first pulse may still carry the old sample
    foreach (pt[i]) begin
      bus(1'b1, 8'h00, {26'h0, pt[i][37:32]});
      u_avp_src_model.put(pt[i][31:16]);
      vld(2);
      check({16'h0, value_out}, {16'h0, pt[i][15:0]});
    end
    bus(1'b1, 8'h0c, 32'h5);
    bus(1'b1, 8'h00, 32'h03);
    bus(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h0);
    // A flush period first, so the checked mean holds one sample value only
    foreach (mt[i]) begin
      u_avp_src_model.put(mt[i][32:17]);
      repeat (20) @(posedge mclk);
      fork u_avp_src_model.fire(mt[i][16]); vld(1); join
      repeat (30) @(posedge mclk);
      fork u_avp_src_model.fire(mt[i][16]); vld(1); join
      check({16'h0, value_out}, {16'h0, mt[i][15:0]});
    end
    bus(1'b1, 8'h08, 32'h100);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h00, 32'h08);
    u_avp_src_model.put(16'h0200);
    repeat (160) @(negedge mclk);
    check({30'h0, lo_hit, hi_hit}, 32'h1);
    bus(1'b1, 8'h00, 32'h0c);
    repeat (160) @(negedge mclk);
    check({30'h0, lo_hit, hi_hit}, 32'h0);
    // Suppression time 5: the fault is held back, then dropped on return
    vld(1);
    u_avp_src_model.put(16'h7fff);
    repeat (120) @(negedge mclk);
    check({16'h0, value_out}, 32'h0200);
    u_avp_src_model.put(16'h0100);
    vld(2);
    check({16'h0, value_out}, 32'h0100);
    bus(1'b1, 8'h00, 32'h1c);
    vld(1);
    u_avp_src_model.put(16'h0200);
    vld(1);
    check({16'h0, value_out}, 32'h0140);
    bus(1'b1, 8'h00, 32'h0c);
    u_avp_src_model.put(16'h7fff);
    repeat (400) @(negedge mclk);
    check({16'h0, value_out}, 32'h7fff);
    print_verdict();
  end
endmodule // tb_analog_value_preprocessor
`default_nettype wire
